//--- oc_pkg.sv
package oc_pkg;

   // ******************************************************************
   // channel layout
   // ******************************************************************
   localparam int NCH       = 4;          // 0,1 digital; 2,3 relay
   localparam int NDIG      = 2;
   localparam int NALM      = 8;          // selectable alarm lines

   // ******************************************************************
   // timing
   // ******************************************************************
   localparam int CLK_PERIOD_NS   = 100;
   localparam int TICK_PERIOD_NS  = 1000000;   // 1 ms base tick
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int ENERGY_PULSE_MS = 20;
   localparam int MS_PER_SEC      = 1000;
   localparam logic [13:0] ONTIME_MAX = 14'h270F;   // 9999 s
   localparam logic [9:0]  ENERGY_MS  = 10'(ENERGY_PULSE_MS);
   localparam logic [9:0]  SEC_MS     = 10'(MS_PER_SEC);

   // ******************************************************************
   // register map, per channel block of 16 bytes
   // ******************************************************************
   localparam logic [1:0] REG_CFG    = 2'h0;   // byte offset 0x0
   localparam logic [1:0] REG_ONTIME = 2'h1;   // byte offset 0x4
   localparam logic [1:0] REG_CMD    = 2'h2;   // byte offset 0x8
   localparam logic [1:0] REG_STAT   = 2'h3;   // byte offset 0xC
   localparam logic [31:0] MAP_LIMIT = 32'h0000_0040;

   // cfg fields
   localparam int CFG_SRC_LSB  = 0;
   localparam int CFG_BEH_LSB  = 2;
   localparam int CFG_MASK_LSB = 8;
   // cmd bits
   localparam int CMD_ON_BIT       = 0;
   localparam int CMD_OFF_BIT      = 1;
   localparam int CMD_ENERGIZE_BIT = 2;
   localparam int CMD_RELEASE_BIT  = 3;
   // stat bits
   localparam int STAT_OUT_BIT  = 0;
   localparam int STAT_RUN_BIT  = 1;
   localparam int STAT_PEND_BIT = 2;

   // reset values
   localparam logic [7:0]  MASK_RST   = 8'h00;
   localparam logic [13:0] ONTIME_RST = 14'h0000;

   // ******************************************************************
   // types
   // ******************************************************************
   typedef enum logic [1:0] {SRC_EXT, SRC_ALARM, SRC_ENERGY, SRC_RSVD}
      oc_src_t;
   typedef enum logic [1:0] {BEH_NORMAL, BEH_TIMED, BEH_COIL, BEH_RSVD}
      oc_beh_t;

endpackage

//--- oc_chan.sv
`timescale 1ns/1ns
module oc_chan
   import oc_pkg::*;
#(
   parameter bit IS_RELAY = 1'b0
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        por_n,
   input  wire oc_src_t     src,
   input  wire oc_beh_t     beh,
   input  wire logic [13:0] ontime,
   input  wire logic        alarm_any,
   input  wire logic        cmd_on,
   input  wire logic        cmd_off,
   input  wire logic        cmd_energize,
   input  wire logic        cmd_release,
   input  wire logic        energy_req,
   input  wire logic        ms_tick,
   output logic             out_q,
   output logic             busy_q,
   output logic             pend_q
);

   // ******************************************************************
   // state
   // ******************************************************************
   logic        run_q, run_d;        // non-coil output, cleared by reset
   logic        coil_q, coil_d;      // coil state, survives hresetn
   logic        alm_prev_q;
   logic [9:0]  ms_q, ms_d;
   logic [13:0] sec_q, sec_d;
   logic        busy_d, pend_d;

   wire is_energy = (src == SRC_ENERGY) && !IS_RELAY;
   wire is_coil   = (beh == BEH_COIL) && !is_energy;
   wire alm_rise  = alarm_any && !alm_prev_q;
   wire alm_fall  = !alarm_any && alm_prev_q;
   wire use_ext   = (src == SRC_EXT);
   wire use_alm   = (src == SRC_ALARM);
   wire trig      = (use_ext && cmd_on) || (use_alm && alm_rise);

   // next output state for each source and behaviour
   always_comb begin
      run_d  = run_q;
      ms_d   = ms_q;
      sec_d  = sec_q;
      busy_d = busy_q;
      pend_d = pend_q || (is_energy && energy_req);
      coil_d = coil_q;
      if (is_energy) begin
         // fixed width pulse, on-time ignored
         if (busy_q) begin
            if (ms_tick) ms_d = ms_q + 10'h001;
            if (ms_tick && ms_q + 10'h001 >= ENERGY_MS) begin
               run_d  = 1'b0;
               busy_d = 1'b0;
            end
         end else if (pend_q) begin
            run_d  = 1'b1;
            busy_d = 1'b1;
            pend_d = energy_req;
            ms_d   = 10'h000;
         end
      end else begin
         pend_d = 1'b0;
         case (beh)
            BEH_NORMAL: begin
               busy_d = 1'b0;                       // no timer in Normal
               // remote: on until off command
               if (use_ext && cmd_off) run_d = 1'b0;
               if (use_ext && cmd_on) run_d = 1'b1;
               // alarm: on at pickup, off at dropout
               if (use_alm && alm_fall) run_d = 1'b0;
               if (use_alm && alm_rise) run_d = 1'b1;
            end
            BEH_TIMED: begin
               // on for the programmed seconds, then off
               if (trig) begin
                  run_d  = (ontime != 14'h0000);
                  busy_d = (ontime != 14'h0000);
                  sec_d  = ontime;
                  ms_d   = 10'h000;
               end else if (use_ext && cmd_off) begin
                  run_d  = 1'b0;
                  busy_d = 1'b0;
               end else if (busy_q && ms_tick) begin
                  ms_d = ms_q + 10'h001;
                  if (ms_q + 10'h001 >= SEC_MS) begin
                     ms_d  = 10'h000;
                     sec_d = sec_q - 14'h0001;
                     if (sec_q == 14'h0001) begin
                        run_d  = 1'b0;
                        busy_d = 1'b0;
                     end
                  end
               end
            end
            BEH_COIL: begin
               // energize sets, release clears, set wins
               if (cmd_release) coil_d = 1'b0;
               if ((use_ext && cmd_energize) || (use_alm && alm_rise))
                  coil_d = 1'b1;
               run_d  = 1'b0;
               busy_d = 1'b0;
            end
            default: begin
               run_d  = 1'b0;
               busy_d = 1'b0;
            end
         endcase
      end
   end

   // volatile state, cleared by control reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_q      <= 1'b0;
         busy_q     <= 1'b0;
         pend_q     <= 1'b0;
         ms_q       <= 10'h000;
         sec_q      <= 14'h0000;
         alm_prev_q <= 1'b0;
      end else begin
         run_q      <= run_d;
         busy_q     <= busy_d;
         pend_q     <= pend_d;
         ms_q       <= ms_d;
         sec_q      <= sec_d;
         alm_prev_q <= alarm_any;
      end
   end

   // retained domain: coil state survives control power loss; the pin keeps its level there in coil mode only
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         coil_q <= 1'b0;
         out_q  <= 1'b0;
      end else begin
         coil_q <= coil_d;
         out_q  <= is_coil ? coil_d : run_d;
      end
   end

endmodule

//--- oc_top.sv
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module oc_top
   import oc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              por_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [NALM-1:0]   alarm_active,
   input  wire logic [NDIG-1:0]   energy_req,
   output logic      [NDIG-1:0]   dout,
   output logic      [1:0]        relay
);

   // ******************************************************************
   // address decode
   // ******************************************************************

   // register slot of a byte address
   function automatic logic [1:0] reg_of(input logic [31:0] a);
      return a[3:2];
   endfunction

   // channel of a byte address
   function automatic logic [1:0] ch_of(input logic [31:0] a);
      return a[5:4];
   endfunction

   // clamp the stored on-time to its documented maximum
   function automatic logic [13:0] clamp_on(input logic [31:0] v);
      logic [31:0] lim;
      lim = {18'h00000, ONTIME_MAX};
      return (v > lim) ? ONTIME_MAX : v[13:0];
   endfunction

   wire        addr_ph  = hsel && hready && htrans[1];
   wire        wr_start = addr_ph && hwrite;
   wire        rd_start = addr_ph && !hwrite;
   wire        in_map   = (haddr < MAP_LIMIT);

   // ******************************************************************
   // bus slave state
   // ******************************************************************
   logic        wr_pend_q;
   logic [31:0] wr_addr_q;
   logic        map_ok_q;

   // zero wait state, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
         map_ok_q  <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= wr_start;
         if (wr_start) wr_addr_q <= haddr;
         if (wr_start) map_ok_q <= in_map;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   wire       wr_hit = wr_pend_q && map_ok_q;
   wire [1:0] wr_reg = reg_of(wr_addr_q);
   wire [1:0] wr_ch  = ch_of(wr_addr_q);

   // ******************************************************************
   // configuration, retained with the coil state
   // ******************************************************************
   oc_src_t     src_q    [NCH];
   oc_beh_t     beh_q    [NCH];
   logic [7:0]  mask_q   [NCH];
   logic [13:0] ontime_q [NCH];

   wire oc_src_t new_src = oc_src_t'(hwdata[CFG_SRC_LSB +: 2]);
   wire oc_beh_t new_beh = oc_beh_t'(hwdata[CFG_BEH_LSB +: 2]);

   // config writes; illegal source or behaviour keeps the old field
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         for (int i = 0; i < NCH; i++) begin
            src_q[i]    <= SRC_EXT;
            beh_q[i]    <= BEH_NORMAL;
            mask_q[i]   <= MASK_RST;
            ontime_q[i] <= ONTIME_RST;
         end
      end else if (wr_hit && wr_reg == REG_CFG) begin
         // relays refuse energy control
         if (new_src != SRC_RSVD
             && !(new_src == SRC_ENERGY && wr_ch >= 2'(NDIG)))
            src_q[wr_ch] <= new_src;
         // energy source ignores behaviour, so no coil hold there
         if (new_beh != BEH_RSVD
             && !(new_src == SRC_ENERGY && new_beh == BEH_COIL))
            beh_q[wr_ch] <= new_beh;
         mask_q[wr_ch] <= hwdata[CFG_MASK_LSB +: 8];
      end else if (wr_hit && wr_reg == REG_ONTIME) begin
         ontime_q[wr_ch] <= clamp_on(hwdata);
      end
   end

   // ******************************************************************
   // millisecond tick
   // ******************************************************************
   logic [15:0] tick_cnt_q;
   logic        ms_tick_q;

   // divide the system clock down to 1 ms
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 16'h0000;
         ms_tick_q  <= 1'b0;
      end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= 16'h0000;
         ms_tick_q  <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         ms_tick_q  <= 1'b0;
      end
   end

   // ******************************************************************
   // channels
   // ******************************************************************
   logic [NCH-1:0] ch_out;
   logic [NCH-1:0] ch_busy;
   logic [NCH-1:0] ch_pend;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire cmd_hit = wr_hit && wr_reg == REG_CMD && wr_ch == 2'(c);
      wire alm_any = |(mask_q[c] & alarm_active);
      wire e_req;
      if (c < NDIG) begin : g_dig
         assign e_req = energy_req[c];
      end else begin : g_rly
         assign e_req = 1'b0;
      end
      oc_chan #(
         .IS_RELAY (c >= NDIG)
      ) u_chan (
         .hclk         (hclk),
         .hresetn      (hresetn),
         .por_n        (por_n),
         .src          (src_q[c]),
         .beh          (beh_q[c]),
         .ontime       (ontime_q[c]),
         .alarm_any    (alm_any),
         .cmd_on       (cmd_hit && hwdata[CMD_ON_BIT]),
         .cmd_off      (cmd_hit && hwdata[CMD_OFF_BIT]),
         .cmd_energize (cmd_hit && hwdata[CMD_ENERGIZE_BIT]),
         .cmd_release  (cmd_hit && hwdata[CMD_RELEASE_BIT]),
         .energy_req   (e_req),
         .ms_tick      (ms_tick_q),
         .out_q        (ch_out[c]),
         .busy_q       (ch_busy[c]),
         .pend_q       (ch_pend[c])
      );
   end

   assign dout  = ch_out[NDIG-1:0];
   assign relay = ch_out[NCH-1:NDIG];

   // ******************************************************************
   // read path
   // ******************************************************************
   wire [1:0]  rd_reg = reg_of(haddr);
   wire [1:0]  rd_ch  = ch_of(haddr);
   logic [31:0] rd_val;

   // read mux; CMD and unmapped addresses read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      if (!in_map) begin
         rd_val = 32'h0000_0000;
      end else if (rd_reg == REG_CFG) begin
         rd_val[CFG_SRC_LSB +: 2]  = src_q[rd_ch];
         rd_val[CFG_BEH_LSB +: 2]  = beh_q[rd_ch];
         rd_val[CFG_MASK_LSB +: 8] = mask_q[rd_ch];
      end else if (rd_reg == REG_ONTIME) begin
         rd_val[13:0] = ontime_q[rd_ch];
      end else if (rd_reg == REG_STAT) begin
         rd_val[STAT_OUT_BIT]  = ch_out[rd_ch];
         rd_val[STAT_RUN_BIT]  = ch_busy[rd_ch];
         rd_val[STAT_PEND_BIT] = ch_pend[rd_ch];
      end
   end

   // read data captured at the address phase, shown in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_start) begin
         hrdata <= rd_val;
      end
   end

endmodule

//--- oc_top_sva.sv
`timescale 1ns/1ns
// ****************************************
// checker for the output block
// ****************************************
module oc_top_sva
   import oc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        por_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [7:0]  alarm_active,
   input wire logic [1:0]  energy_req,
   input wire logic [1:0]  dout,
   input wire logic [1:0]  relay
);
   localparam int LO = 19 * TICK_CYCLES;
   localparam int HI = 21 * TICK_CYCLES;
   logic        ap_q;
   logic        aw_q;
   logic [31:0] aa_q;
   logic [1:0]  src_q;
   logic [1:0]  beh_q;
   logic [7:0]  mask_q;
   logic [15:0] hcnt_q;
   logic        wr_cmd;
   logic        rel_cmd;
   logic        any_al;
   logic        ext_nrm;
   logic        alm_nrm;
   logic        coil;

   // write data phase decode for channel 0
   assign wr_cmd  = ap_q && aw_q && aa_q == 32'h8;
   assign rel_cmd = wr_cmd && hwdata[3] && !hwdata[2];
   assign any_al  = |(mask_q & alarm_active);
   assign ext_nrm = src_q == SRC_EXT && beh_q == BEH_NORMAL;
   assign alm_nrm = src_q == SRC_ALARM && beh_q == BEH_NORMAL;
   assign coil    = beh_q == BEH_COIL;

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= 1'b0;
         aw_q <= 1'b0;
         aa_q <= 32'h0;
      end else begin
         ap_q <= hsel && hready && htrans[1];
         aw_q <= hwrite;
         aa_q <= haddr;
      end
   end

   // shadow of channel 0 setup, kept over control resets
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         src_q  <= 2'h0;
         beh_q  <= 2'h0;
         mask_q <= 8'h0;
      end else if (ap_q && aw_q && aa_q == 32'h0) begin
         src_q  <= hwdata[1:0];
         beh_q  <= hwdata[3:2];
         mask_q <= hwdata[15:8];
      end
   end

   // length of the present high run on output 0
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hcnt_q <= 16'h0;
      else if (dout[0])
         hcnt_q <= hcnt_q + 16'h1;
      else
         hcnt_q <= 16'h0;
   end

   default clocking dcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_remote_on:
      assert property (ext_nrm && wr_cmd && hwdata[0] |=> dout[0])
      else $error("on command not applied");
   a_remote_off:
      assert property (ext_nrm && wr_cmd && hwdata[1] && !hwdata[0]
         |=> !dout[0]) else $error("off command not applied");
   a_alarm_pickup:
      assert property (alm_nrm && $rose(any_al) |-> ##[1:3] dout[0])
      else $error("alarm pickup missed");
   a_alarm_dropout:
      assert property (alm_nrm && $fell(any_al) |-> ##[1:3] !dout[0])
      else $error("alarm dropout missed");
   a_energize_on:
      assert property (coil && src_q == SRC_EXT && wr_cmd && hwdata[2]
         |=> dout[0]) else $error("energize missed");
   a_coil_release:
      assert property (coil && rel_cmd |=> !dout[0])
      else $error("release missed");
   a_coil_retain:
      assert property (disable iff (!por_n)
         coil && dout[0] && !rel_cmd |=> dout[0]) else $error("coil lost");
   a_pulse_width:
      assert property (src_q == SRC_ENERGY && $fell(dout[0])
         |-> hcnt_q >= LO && hcnt_q <= HI) else $error("bad pulse width");
   a_energy_start:
      assert property (src_q == SRC_ENERGY && energy_req[0]
         |-> ##[1:3] dout[0]) else $error("energy pulse missing");
   a_reset_off:
      assert property (disable iff (!por_n)
         !hresetn [*2] |-> coil || !dout[0]) else $error("on in reset");

   c_energy: cover property (src_q == SRC_ENERGY && $fell(dout[0]));
   c_coil_rst: cover property (disable iff (!por_n)
      coil && dout[0] && !hresetn);
   c_alarm_on: cover property (any_al && dout[0]);
endmodule

bind oc_top oc_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
   .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .alarm_active(alarm_active),
   .energy_req(energy_req), .dout(dout), .relay(relay)
);

//--- oc_load.sv
`timescale 1ns/1ns
// ****************************************
// switched load on the four outputs
// ****************************************
module oc_load
   import oc_pkg::*;
(
   input wire logic            hclk,
   input wire logic [NDIG-1:0] dout,
   input wire logic [1:0]      relay
);
   logic [NCH-1:0] pins;
   int             run [NCH] = '{default: 0};
   int             wid [NCH] = '{default: 0};
   int             cnt [NCH] = '{default: 0};

   assign pins = {relay, dout};

   // closed time of the last closure and closure count, in clocks
   always @(posedge hclk) begin
      for (int i = 0; i < NCH; i++) begin
         if (pins[i] === 1'b1) begin
            run[i] = run[i] + 1;
         end else if (run[i] != 0) begin
            wid[i] = run[i];
            cnt[i] = cnt[i] + 1;
            run[i] = 0;
         end
      end
   end
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
// ****************************************
// bench for the output block
// ****************************************
module tb_top
   import oc_pkg::*;
;
   localparam int TCK = 4;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} oc_row_t;
   logic        hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, energy_req, dout, relay;
   logic [2:0]  hsize;
   logic [7:0]  alarm_active;
   logic [3:0]  pins;
   int          error_cnt, num_checks, n;
   oc_row_t     rows [9] = '{
      '{32'h4, 32'h3FFF, 32'h270F}, '{32'h4, 32'h270F, 32'h270F},
      '{32'h24, 32'h1234, 32'h1234}, '{32'h8, 32'h0, 32'h0},
      '{32'h40, 32'hFFFF_FFFF, 32'h0}, '{32'h20, 32'h106, 32'h104},
      '{32'h10, 32'h2, 32'h2}, '{32'h10, 32'hA, 32'h2},
      '{32'h30, 32'h109, 32'h109} // coil hold on unary alarm
   };

   assign hready = hreadyout;
   assign pins   = {relay, dout};
   oc_top #(.TICK_CYCLES(TCK)) dut (
      .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .alarm_active(alarm_active),
      .energy_req(energy_req), .dout(dout), .relay(relay)
   );
   oc_load load (.hclk(hclk), .dout(dout), .relay(relay));

   // clock
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task chk(input logic [31:0] s, input logic [31:0] e, input string m);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, s, e);
      end
   endtask

   // one bus phase, ends at the edge where ready is seen
   task rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) chk(32'(hreadyout), 32'h1, "ready timeout");
   endtask

   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
      chk(32'(hresp), 32'h0, "response");
   endtask

   task wcnt(input int ch, input int c);
      int k;
      k = 0;
      while (load.cnt[ch] < c && k < 6000) begin
         @(posedge hclk);
         k++;
      end
      if (load.cnt[ch] < c) chk(32'(load.cnt[ch]), 32'(c), "no closure");
   endtask

   // control power loss for three clocks
   task crst;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
   endtask

   task end_of_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the run length
   initial begin
      repeat (30000) @(posedge hclk);
      error_cnt++;
      end_of_test;
   end

   // main sequence
   initial begin
      {hresetn, por_n, hsel, hwrite, htrans, energy_req} = 8'h0;
      {haddr, hwdata, alarm_active} = 72'h0;
      hsize = 3'h2;
      error_cnt = 0;
      num_checks = 0;
      repeat (10) @(posedge hclk);
      por_n <= 1'b1;
      hresetn <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         xfer(1'b0, 32'(4 * i), 32'h0);
         chk(rd, 32'h0, "reset value");
      end
      foreach (rows[i]) begin
         xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].e, "readback");
      end
      for (int c = 0; c < 4; c += 2) begin
         xfer(1'b1, 32'(16 * c), 32'h0);
         xfer(1'b1, 32'(16 * c + 8), 32'h1);
         repeat (40) @(negedge hclk);
         chk(32'(pins[c]), 32'h1, "held on");
         xfer(1'b1, 32'(16 * c + 8), 32'h2);
         @(negedge hclk);
         chk(32'(pins[c]), 32'h0, "off");
      end
      xfer(1'b1, 32'h0, 32'h2401);
      alarm_active <= 8'h02;
      repeat (5) @(negedge hclk);
      chk(32'(dout[0]), 32'h0, "unlinked alarm");
      @(posedge hclk);
      alarm_active <= 8'h22;
      repeat (5) @(negedge hclk);
      chk(32'(dout[0]), 32'h1, "pickup");
      @(posedge hclk);
      alarm_active <= 8'h00;
      repeat (5) @(negedge hclk);
      chk(32'(dout[0]), 32'h0, "dropout");
      xfer(1'b1, 32'h34, 32'h1);
      xfer(1'b1, 32'h30, 32'h105);
      n = load.cnt[3];
      alarm_active <= 8'h01;
      xfer(1'b0, 32'h3C, 32'h0);
      chk(rd, 32'h3, "timed running");
      wcnt(3, n + 1);
      alarm_active <= 8'h00;
      chk(32'(load.wid[3] >= 999 * TCK && load.wid[3] <= 1001 * TCK),
         32'h1, "timed width");
      xfer(1'b1, 32'h0, 32'h2);
      n = load.cnt[0];
      energy_req <= 2'h3;
      @(posedge hclk);
      energy_req <= 2'h0;
      repeat (10) @(posedge hclk);
      energy_req <= 2'h3;
      @(posedge hclk);
      energy_req <= 2'h0;
      xfer(1'b0, 32'hC, 32'h0);
      chk(rd, 32'h7, "pulse pending");
      wcnt(0, n + 2);
      repeat (100) @(posedge hclk);
      chk(32'(load.cnt[0] - n), 32'h2, "pulse count");
      chk(32'(load.wid[0] >= 19 * TCK && load.wid[0] <= 21 * TCK),
         32'h1, "energy width");
      xfer(1'b1, 32'h0, 32'h8);
      xfer(1'b1, 32'h8, 32'h4);
      xfer(1'b1, 32'h28, 32'h1);
      crst();
      chk(32'(pins), 32'h1, "after power loss");
      xfer(1'b0, 32'h34, 32'h0);
      chk(rd, 32'h1, "setup kept");
      xfer(1'b1, 32'h8, 32'h8);
      @(negedge hclk);
      chk(32'(dout[0]), 32'h0, "released");
      xfer(1'b1, 32'h0, 32'h0);
      xfer(1'b1, 32'h8, 32'h1);
      crst();
      chk(32'(dout[0]), 32'h0, "normal off in reset");
      end_of_test;
   end
endmodule
